// >>> comparator_control_map.vh
// Notes on behaviour
// - Enable bit 10 turns comparator on.
// - Bits 9:8 pick negative input source.
// - Bits 7:6 route result: pin or interrupt.
// - Polarity bit 5 inverts comparator output sense.
// - Bits 4:3 pick slow or fast response.
// - Bit 2 enables about 7.5 mV hysteresis.
// - Rising edge sets bit 1; write one clears.
// - Falling edge sets bit 0; sticky until cleared.
// - Sixteen-bit register; bits 15:11 read zero.
// - Positive input always from channel three path.
// - Result feeds interrupt, logic array, converter, pin.
`ifndef COMPARATOR_CONTROL_MAP_VH
`define COMPARATOR_CONTROL_MAP_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CMP_CTRL_ADDR      32'hffff_0444
`define CMP_CTRL_RESET     16'h0000
`define CMP_CTRL_WMASK     16'h07fc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ON             10
`define NEGSEL_HI          9
`define NEGSEL_LO          8
`define ROUTE_HI           7
`define ROUTE_LO           6
`define BIT_POL            5
`define SPEED_HI           4
`define SPEED_LO           3
`define BIT_HYST           2
`define BIT_RISE           1
`define BIT_FALL           0

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define NEG_HALF_SUPPLY    2'h0
`define NEG_CHANNEL_THREE  2'h1
`define NEG_CONVERTER_OUT  2'h2
`define ROUTE_PIN          2'h2
`define ROUTE_IRQ          2'h3
`define SPEED_SLOW         2'h0
`define SPEED_FAST         2'h3

`endif

// >>> voltage_comparator_control.v
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
`include "comparator_control_map.vh"
module voltage_comparator_control
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire [31:0] regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [15:0] regRdata,
  input  wire        rawResult,
  output wire        analogEnable,
  output wire [1:0]  negInputSelect,
  output wire        positiveFromChannelThree,
  output wire        fastResponse,
  output wire        hysteresisEnable,
  output wire        invertSense,
  output reg         resultOutputPin,
  output reg         resultIrq,
  output reg         resultToLogicArray,
  output reg         resultToConverterStart
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  reg  [15:0] ctrl;
  reg  [15:0] next_ctrl;
  reg         syncA;
  reg         syncB;
  reg         lastResult;
  reg         next_resultOutputPin;
  reg         next_resultIrq;
  reg         next_resultToLogicArray;
  reg         next_resultToConverterStart;
  reg  [15:0] next_regRdata;
  wire        hit;
  wire        wrHit;
  wire        rdHit;
  wire        rise;
  wire        fall;
  wire        enabled;
  wire        resOn;
  wire [1:0]  route;
  wire        routePin;
  wire        routeIrq;
  wire        flagPending;
  wire        riseSet;
  wire        fallSet;
  wire        riseClear;
  wire        fallClear;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only the one full address is mapped; every other address is ignored.
  assign hit = (regAddr == `CMP_CTRL_ADDR);

  assign wrHit = regWrite & hit;

  assign rdHit = regRead & hit;

  // ----------------------------------------------------------------
  // Result synchroniser
  // ----------------------------------------------------------------
  // Two-stage synchroniser.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 1'h0;
    end
    else
    begin
      syncA <= rawResult;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncB <= 1'h0;
    end
    else
    begin
      syncB <= syncA;
    end
  end

  // The history flop resets to the idle level, so no false edge follows reset.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastResult <= 1'h0;
    end
    else
    begin
      lastResult <= syncB;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Only the second stage is compared, so each transition is seen once.
  assign rise = syncB & ~lastResult;

  assign fall = ~syncB & lastResult;

  assign enabled = ctrl[`BIT_ON];

  assign resOn = enabled & syncB;

  // ----------------------------------------------------------------
  // Flag set and clear terms
  // ----------------------------------------------------------------
  // Rising edge sets.
  assign riseSet = rise & enabled;

  assign fallSet = fall & enabled;

  assign riseClear = wrHit & regWdata[`BIT_RISE];

  assign fallClear = wrHit & regWdata[`BIT_FALL];

  // ----------------------------------------------------------------
  // Control register next value
  // ----------------------------------------------------------------
  always @*
  begin
    next_ctrl = ctrl;
    if (wrHit)
    begin
      next_ctrl[`BIT_ON] = regWdata[`BIT_ON];
    end
    if (wrHit)
    begin
      next_ctrl[`NEGSEL_HI:`NEGSEL_LO] = regWdata[`NEGSEL_HI:`NEGSEL_LO];
    end
    if (wrHit)
    begin
      next_ctrl[`ROUTE_HI:`ROUTE_LO] = regWdata[`ROUTE_HI:`ROUTE_LO];
    end
    if (wrHit)
    begin
      next_ctrl[`BIT_POL] = regWdata[`BIT_POL];
    end
    if (wrHit)
    begin
      next_ctrl[`SPEED_HI:`SPEED_LO] = regWdata[`SPEED_HI:`SPEED_LO];
    end
    if (wrHit)
    begin
      next_ctrl[`BIT_HYST] = regWdata[`BIT_HYST];
    end
    // Rising flag, set wins.
    // A clear in the same cycle as a new edge leaves the flag set, so that edge is kept.
    if (riseSet)
    begin
      next_ctrl[`BIT_RISE] = 1'h1;
    end
    else if (riseClear)
    begin
      next_ctrl[`BIT_RISE] = 1'h0;
    end
    if (fallSet)
    begin
      next_ctrl[`BIT_FALL] = 1'h1;
    end
    else if (fallClear)
    begin
      next_ctrl[`BIT_FALL] = 1'h0;
    end
    next_ctrl[15:11] = 5'h00;
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= `CMP_CTRL_RESET;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  // Enable drive.
  assign analogEnable = ctrl[`BIT_ON];

  // Negative input; reserved code passed as is.
  assign negInputSelect = ctrl[`NEGSEL_HI:`NEGSEL_LO];

  assign positiveFromChannelThree = 1'h1;

  assign invertSense = ctrl[`BIT_POL];

  assign fastResponse = (ctrl[`SPEED_HI:`SPEED_LO] == `SPEED_FAST);

  assign hysteresisEnable = ctrl[`BIT_HYST];

  // ----------------------------------------------------------------
  // Route decode
  // ----------------------------------------------------------------
  // Reserved route codes drive neither the pin nor the interrupt.
  assign route = ctrl[`ROUTE_HI:`ROUTE_LO];

  assign routePin = (route == `ROUTE_PIN);

  assign routeIrq = (route == `ROUTE_IRQ);

  assign flagPending = ctrl[`BIT_RISE] | ctrl[`BIT_FALL];

  // ----------------------------------------------------------------
  // Output next values
  // ----------------------------------------------------------------
  // The analog stage applies the polarity, so the synced level is final.
  always @*
  begin
    next_resultOutputPin = resOn & routePin;
    next_resultIrq = enabled & routeIrq & flagPending;
    next_resultToLogicArray = resOn;
    next_resultToConverterStart = riseSet;
    next_regRdata = 16'h0000;
    if (rdHit)
    begin
      next_regRdata = {5'h00, ctrl[10:0]};
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultOutputPin <= 1'h0;
    end
    else
    begin
      resultOutputPin <= next_resultOutputPin;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultIrq <= 1'h0;
    end
    else
    begin
      resultIrq <= next_resultIrq;
    end
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultToLogicArray <= 1'h0;
    end
    else
    begin
      resultToLogicArray <= next_resultToLogicArray;
    end
  end

  // One pulse per synced rising edge while enabled; the converter must not see a level.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resultToConverterStart <= 1'h0;
    end
    else
    begin
      resultToConverterStart <= next_resultToConverterStart;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  // Read data stand for one cycle only and are zero otherwise.
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= 16'h0000;
    end
    else
    begin
      regRdata <= next_regRdata;
    end
  end

endmodule

// >>> voltage_comparator_control_assertions.sv
`timescale 1ns/1ns
`include "comparator_control_map.vh"
module voltage_comparator_control_checker
(
  input wire        core_clk,
  input wire        rst_n,
  input wire [31:0] regAddr,
  input wire [15:0] regWdata,
  input wire        regWrite,
  input wire        regRead,
  input wire [15:0] regRdata,
  input wire        rawResult,
  input wire        analogEnable,
  input wire [1:0]  negInputSelect,
  input wire        fastResponse,
  input wire        hysteresisEnable,
  input wire        invertSense,
  input wire        resultToConverterStart
);
  // ----------
  // Checks
  // ----------
  wire wrHit = regWrite && regAddr == `CMP_CTRL_ADDR;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence riseSeen;
    $rose(rawResult) && analogEnable;
  endsequence
  en_wr_a: assert property (wrHit |=> analogEnable == $past(regWdata[10]))
    else $error("enable not applied");
  neg_wr_a: assert property (wrHit |=> negInputSelect == $past(regWdata[9:8]))
    else $error("input select not applied");
  pol_wr_a: assert property (wrHit |=> invertSense == $past(regWdata[5]))
    else $error("polarity not applied");
  speed_wr_a: assert property (wrHit |=> fastResponse == ($past(regWdata[4:3]) == 2'h3))
    else $error("speed not applied");
  hyst_wr_a: assert property (wrHit |=> hysteresisEnable == $past(regWdata[2]))
    else $error("hysteresis not applied");
  rsv_zero_a: assert property (regRead |=> regRdata[15:11] == 5'h00)
    else $error("reserved bits not zero");
  conv_rise_a: assert property (riseSeen |-> ##[1:4] resultToConverterStart)
    else $error("no conversion start");
  conv_once_a: assert property (resultToConverterStart |=> !resultToConverterStart)
    else $error("conversion start too long");
endmodule

// >>> voltage_comparator_control_tb.sv
`timescale 1ns/1ns
`include "comparator_control_map.vh"
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errTotal++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module voltage_comparator_control_tb;
  reg core_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rawResult = 1'b0;
  reg [31:0] regAddr = `CMP_CTRL_ADDR;
  reg [15:0] regWdata = 16'h0000;
  wire [15:0] regRdata;
  wire [1:0] negInputSelect;
  wire analogEnable, positiveFromChannelThree, fastResponse, hysteresisEnable, invertSense;
  wire resultOutputPin, resultIrq, resultToLogicArray, resultToConverterStart;
  int errTotal = 0, checkCount = 0;
  always #20 core_clk = ~core_clk;
  voltage_comparator_control dut_u (
    .core_clk                 (core_clk),
    .rst_n                    (rst_n),
    .regAddr                  (regAddr),
    .regWdata                 (regWdata),
    .regWrite                 (regWrite),
    .regRead                  (regRead),
    .regRdata                 (regRdata),
    .rawResult                (rawResult),
    .analogEnable             (analogEnable),
    .negInputSelect           (negInputSelect),
    .positiveFromChannelThree (positiveFromChannelThree),
    .fastResponse             (fastResponse),
    .hysteresisEnable         (hysteresisEnable),
    .invertSense              (invertSense),
    .resultOutputPin          (resultOutputPin),
    .resultIrq                (resultIrq),
    .resultToLogicArray       (resultToLogicArray),
    .resultToConverterStart   (resultToConverterStart)
  );
  // ----------
  // Bus tasks
  // ----------
  task wr(input [31:0] a, input [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task rd(input [31:0] a, input [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask
  // Four edges cover the two-stage synchroniser plus the flag update.
  task drive(input v);
    @(posedge core_clk);
    rawResult <= v;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task endOfTest;
    $display("checks %0d errors %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #200000 errTotal++;
    endOfTest();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`CMP_CTRL_ADDR, `CMP_CTRL_RESET);
    wr(`CMP_CTRL_ADDR, 16'hffff);
    wr(32'h0000_0000, 16'h0000);
    rd(`CMP_CTRL_ADDR, 16'h07fc);
    rd(32'h0000_0000, 16'h0000);
    `CHK({analogEnable, hysteresisEnable, invertSense}, 3'h7)
    for (int i = 0; i < 4; i++)
    begin
      wr(`CMP_CTRL_ADDR, {5'h00, 1'h1, i[1:0], 3'h0, i[1:0], 3'h0});
      `CHK({negInputSelect, fastResponse, invertSense}, {i[1:0], i == 3, 1'h0})
    end
    wr(`CMP_CTRL_ADDR, 16'h04c0);
    drive(1'h1);
    rd(`CMP_CTRL_ADDR, 16'h04c2);
    `CHK(resultIrq, 1'h1)
    drive(1'h0);
    rd(`CMP_CTRL_ADDR, 16'h04c3);
    wr(`CMP_CTRL_ADDR, 16'h04c2);
    rd(`CMP_CTRL_ADDR, 16'h04c1);
    wr(`CMP_CTRL_ADDR, 16'h04c1);
    rd(`CMP_CTRL_ADDR, 16'h04c0);
    `CHK(resultIrq, 1'h0)
    wr(`CMP_CTRL_ADDR, 16'h0480);
    drive(1'h1);
    `CHK({resultOutputPin, resultToLogicArray, resultIrq}, 3'h6)
    wr(`CMP_CTRL_ADDR, 16'h0003);
    drive(1'h0);
    rd(`CMP_CTRL_ADDR, 16'h0000);
    `CHK(positiveFromChannelThree, 1'h1)
    endOfTest();
  end
endmodule
bind voltage_comparator_control voltage_comparator_control_checker chk_u (
  .core_clk               (core_clk),
  .rst_n                  (rst_n),
  .regAddr                (regAddr),
  .regWdata               (regWdata),
  .regWrite               (regWrite),
  .regRead                (regRead),
  .regRdata               (regRdata),
  .rawResult              (rawResult),
  .analogEnable           (analogEnable),
  .negInputSelect         (negInputSelect),
  .fastResponse           (fastResponse),
  .hysteresisEnable       (hysteresisEnable),
  .invertSense            (invertSense),
  .resultToConverterStart (resultToConverterStart)
);
